/* File: phy_mdix_cable_irq_flags.sv */
// phy status, crossover, cable length and interrupt flag registers
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/10ps

// Summary of operation
// - polarity status bit 4, reversed reads one
// - device phy reset restores sticky bit defaults
// - soft reset bit set keeps sticky values
// - fault enable defaults one in fiber mode
// - override bit 15 picks register or straps
// - enable/state bits pick crossover mode
// - auto strap wins, else manual strap
// - cable estimate bits 15:12, reset zero
// - estimate valid only on 100 copper links
// - flags read-only, latch on enabled event
// - reading flags register clears all but same-cycle events
// - mask register enables each flag source
// - mask one enables, resets to zero
// - bit 9 latches on link up
// - bit 8 latches on wake event
// - bit 7 latches on energy detected
// - bit 6 latches on negotiation done
// - bit 5 latches on remote fault
// - bit 4 latches on link down
// - bit 3 latches on partner acknowledge
// - bit 2 parallel fault, bit 1 page
module phy_mdix_cable_irq_flags
  import phy_regs_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // avalon-mm slave
  input  wire logic [6:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [1:0]       avs_response,
  // phy status inputs
  input  wire logic        polarity_reversed,
  input  wire logic        fiber_mode,
  input  wire logic        auto_mdix_strap,
  input  wire logic        manual_mdix_strap,
  input  wire logic [3:0]  cable_length_in,
  input  wire logic        link_100_copper,
  input  wire logic        cable_fault,
  // interrupt events
  input  wire logic        link_status,
  input  wire logic        wake_event,
  input  wire logic        energy_detected,
  input  wire logic        negotiation_done,
  input  wire logic        remote_fault,
  input  wire logic        partner_ack,
  input  wire logic        parallel_detect_fault,
  input  wire logic        page_received,
  // outputs to the phy core
  output logic             crossover_auto,
  output logic             crossover_swap,
  output logic             far_end_fault_enable,
  output logic             sqe_test_off,
  output logic             phy_irq
);

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic        crossover_override;     // register control of crossover
  logic        crossover_auto_enable;  // auto crossover enable
  logic        crossover_manual_state; // manual crossover state
  logic        sqe_off_reg;            // heartbeat disable
  logic        fault_en_reg;           // far end fault enable
  logic        fault_en_init_reg;      // fault default taken after reset
  logic        phy_soft_reset_bit;     // keeps sticky bits over phy reset
  logic        polarity_reversed_flag; // sampled polarity state
  logic [3:0]  cable_length_estimate;  // cable length estimate
  logic [11:0] cable_low_reg;          // reserved low cable bits
  logic [15:0] flags_reg;              // interrupt source flags
  logic [15:0] interrupt_enable_mask_reg;
  logic        link_prev_reg;          // previous link status
  logic        energy_prev_reg;        // previous energy detect
  logic [15:0] events;                 // raw events this cycle
  logic        ack_reg;                // answer phase of access
  xover_mode_t xover_mode;             // decoded crossover mode

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  logic [4:0]  word_idx;   // word index of access
  logic        aligned;    // byte address is word aligned
  logic        take_wr;    // write takes effect this edge
  logic        take_rd;    // read completes this edge
  logic        wr_lo;      // low byte lane enabled
  logic        wr_hi;      // high byte lane enabled
  logic        dev_reset;  // device phy reset strobe
  logic        sticky_rst; // sticky bits return to defaults

  assign word_idx = avs_address[6:2];
  assign aligned  = (avs_address[1:0] == 2'h0);
  assign take_wr  = avs_write & ack_reg;
  assign take_rd  = avs_read & ack_reg;
  assign wr_lo    = avs_byteenable[0];
  assign wr_hi    = avs_byteenable[1];
  assign dev_reset = take_wr && aligned && word_idx == idx_soft_device_reset_control_reg
                     && wr_lo && avs_writedata[pos_dev_reset];
  // sticky bits drop back only when the soft reset hold bit is clear
  assign sticky_rst = dev_reset && !phy_soft_reset_bit;

  // one wait cycle, then answer; request must be held meanwhile
  // waitrequest kept in its own flop so the pin is glitch free
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_reg         <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && !ack_reg) begin
      ack_reg         <= 1'b1;
      avs_waitrequest <= 1'b0;
    end else begin
      ack_reg         <= 1'b0;
      avs_waitrequest <= 1'b1;
    end
  end

  assign avs_response    = 2'h0;

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  logic [15:0] rd_word; // selected register contents

  // address decode; unmapped words read zero
  always_comb begin
    rd_word = 16'h0000;
    if (!aligned) begin
      rd_word = 16'h0000;
    end else if (word_idx == idx_special_mode) begin
      rd_word[pos_override]     = crossover_override;
      rd_word[pos_auto_enable]  = crossover_auto_enable;
      rd_word[pos_manual_state] = crossover_manual_state;
      rd_word[pos_sqe_off]      = sqe_off_reg;
      rd_word[pos_fault_enable] = fault_en_reg;
      rd_word[pos_polarity]     = polarity_reversed_flag;
    end else if (word_idx == idx_cable_length) begin
      rd_word = {cable_length_estimate, cable_low_reg};
    end else if (word_idx == idx_int_flags) begin
      rd_word = flags_reg;
    end else if (word_idx == idx_int_mask) begin
      rd_word = interrupt_enable_mask_reg;
    end else if (word_idx == idx_soft_device_reset_control_reg) begin
      rd_word[pos_soft_reset] = phy_soft_reset_bit;
    end
  end

  // readdata registered; valid at the edge waitrequest is low
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_reg) begin
      avs_readdata <= {16'h0000, rd_word};
    end
  end

  // ----------------------------------------------------------------------
  // crossover and heartbeat control, sticky over soft reset
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      crossover_override     <= 1'b0;
      crossover_auto_enable  <= 1'b0;
      crossover_manual_state <= 1'b0;
      sqe_off_reg            <= 1'b0;
    end else if (sticky_rst) begin
      crossover_override     <= 1'b0;
      crossover_auto_enable  <= 1'b0;
      crossover_manual_state <= 1'b0;
      sqe_off_reg            <= 1'b0;
    end else if (take_wr && aligned && word_idx == idx_special_mode) begin
      if (wr_hi) begin
        crossover_override     <= avs_writedata[pos_override];
        crossover_auto_enable  <= avs_writedata[pos_auto_enable];
        crossover_manual_state <= avs_writedata[pos_manual_state];
        sqe_off_reg            <= avs_writedata[pos_sqe_off];
      end
    end
  end

  // fault enable loads fiber mode after reset and on every device reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fault_en_reg      <= 1'b0;
      fault_en_init_reg <= 1'b0;
    end else if (!fault_en_init_reg || dev_reset) begin
      fault_en_reg      <= fiber_mode;
      fault_en_init_reg <= 1'b1;
    end else if (take_wr && aligned && word_idx == idx_special_mode
                 && wr_lo) begin
      fault_en_reg <= avs_writedata[pos_fault_enable];
    end
  end

  // soft reset hold bit, software owned
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phy_soft_reset_bit <= 1'b0;
    end else if (take_wr && aligned && word_idx == idx_soft_device_reset_control_reg
                 && wr_lo) begin
      phy_soft_reset_bit <= avs_writedata[pos_soft_reset];
    end
  end

  // crossover mode decode; reserved 11 treated as auto
  always_comb begin
    if (crossover_override) begin
      if (crossover_auto_enable) begin
        xover_mode = xover_auto;
      end else if (crossover_manual_state) begin
        xover_mode = xover_cross;
      end else begin
        xover_mode = xover_none;
      end
    end else if (auto_mdix_strap) begin
      xover_mode = xover_auto;
    end else if (manual_mdix_strap) begin
      xover_mode = xover_cross;
    end else begin
      xover_mode = xover_none;
    end
  end

  // control outputs straight from flip-flops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      crossover_auto       <= 1'b0;
      crossover_swap       <= 1'b0;
      far_end_fault_enable <= 1'b0;
      sqe_test_off         <= 1'b0;
    end else begin
      crossover_auto       <= (xover_mode == xover_auto);
      crossover_swap       <= (xover_mode == xover_cross);
      far_end_fault_enable <= fault_en_reg;
      sqe_test_off         <= sqe_off_reg;
    end
  end

  // ----------------------------------------------------------------------
  // status: polarity and cable length
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      polarity_reversed_flag <= 1'b0;
      cable_length_estimate  <= cable_reset_val;
    end else begin
      polarity_reversed_flag <= polarity_reversed;
      // estimate held unless on a clean 100 copper link
      if (link_100_copper && !cable_fault) begin
        cable_length_estimate <= cable_length_in;
      end
    end
  end

  // reserved low cable bits are plain storage
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cable_low_reg <= cable_low_val;
    end else if (take_wr && aligned && word_idx == idx_cable_length) begin
      if (wr_lo) begin
        cable_low_reg[7:0] <= avs_writedata[7:0];
      end
      if (wr_hi) begin
        cable_low_reg[11:8] <= avs_writedata[11:8];
      end
    end
  end

  // ----------------------------------------------------------------------
  // interrupt flags and mask
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      link_prev_reg   <= 1'b0;
      energy_prev_reg <= 1'b0;
    end else begin
      link_prev_reg   <= link_status;
      energy_prev_reg <= energy_detected;
    end
  end

  // event vector in flag bit order
  always_comb begin
    events    = 16'h0000;
    events[9] = link_status & ~link_prev_reg;
    events[8] = wake_event;
    events[7] = energy_detected & ~energy_prev_reg;
    events[6] = negotiation_done;
    events[5] = remote_fault;
    events[4] = ~link_status & link_prev_reg;
    events[3] = partner_ack;
    events[2] = parallel_detect_fault;
    events[1] = page_received;
  end

  logic rd_flags; // flags register read completes
  assign rd_flags = take_rd && aligned && word_idx == idx_int_flags;

  // latch enabled events; clear on read, a new event wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flags_reg <= flags_reset_val;
    end else begin
      flags_reg <= ((rd_flags ? 16'h0000 : flags_reg)
                   | (events & interrupt_enable_mask_reg))
                   & flag_mask_bits;
    end
  end

  // mask register, one enables a source
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      interrupt_enable_mask_reg <= mask_reset_val;
    end else if (take_wr && aligned && word_idx == idx_int_mask) begin
      if (wr_lo) begin
        interrupt_enable_mask_reg[7:0] <= avs_writedata[7:0]
                                          & flag_mask_bits[7:0];
      end
      if (wr_hi) begin
        interrupt_enable_mask_reg[15:8] <= avs_writedata[15:8]
                                           & flag_mask_bits[15:8];
      end
    end
  end

  // irq follows enabled flags one cycle later
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phy_irq <= 1'b0;
    end else begin
      phy_irq <= |(flags_reg & interrupt_enable_mask_reg);
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  AST_POL_TRACK: assert property (@(posedge mclk) disable iff (rst)
    1'b1 ##1 polarity_reversed_flag == $past(polarity_reversed))
    else $error("polarity flag does not follow input");
  AST_STICKY_KEEP: assert property (@(posedge mclk) disable iff (rst)
    dev_reset && phy_soft_reset_bit
    |=> crossover_override == $past(crossover_override)
        && sqe_off_reg == $past(sqe_off_reg))
    else $error("sticky bit lost under soft reset hold");
  AST_STICKY_CLR: assert property (@(posedge mclk) disable iff (rst)
    sticky_rst |=> !crossover_override && !crossover_auto_enable)
    else $error("sticky bit not restored");
  AST_FAULT_DEF: assert property (@(posedge mclk) disable iff (rst)
    dev_reset |=> fault_en_reg == $past(fiber_mode))
    else $error("fault enable default wrong");
  AST_XOVER_REG: assert property (@(posedge mclk) disable iff (rst)
    crossover_override && !crossover_auto_enable && crossover_manual_state
    |=> crossover_swap && !crossover_auto)
    else $error("manual crossover not applied");
  AST_XOVER_STRAP: assert property (@(posedge mclk) disable iff (rst)
    !crossover_override && auto_mdix_strap |=> crossover_auto)
    else $error("auto strap ignored");
  AST_FLAG_LATCH: assert property (@(posedge mclk) disable iff (rst)
    wake_event && interrupt_enable_mask_reg[8] |=> flags_reg[8])
    else $error("enabled wake event not latched");
  AST_FLAG_MASKED: assert property (@(posedge mclk) disable iff (rst)
    !flags_reg[5] && !interrupt_enable_mask_reg[5] |=> !flags_reg[5])
    else $error("masked flag latched");
  AST_READ_CLR: assert property (@(posedge mclk) disable iff (rst)
    rd_flags && events == 16'h0000 |=> flags_reg == 16'h0000)
    else $error("flags not cleared by read");
  AST_IRQ: assert property (@(posedge mclk) disable iff (rst)
    |(flags_reg & interrupt_enable_mask_reg) |=> phy_irq)
    else $error("irq missing for enabled flag");

  COV_READ_CLR: cover property (@(posedge mclk) disable iff (rst)
    flags_reg != 16'h0000 ##1 rd_flags);
  COV_IRQ: cover property (@(posedge mclk) disable iff (rst)
    !phy_irq ##1 phy_irq);
  COV_STICKY: cover property (@(posedge mclk) disable iff (rst)
    dev_reset && phy_soft_reset_bit);
  COV_AUTO: cover property (@(posedge mclk) disable iff (rst)
    crossover_override && crossover_auto);

endmodule

/* File: phy_regs_pkg.sv */
// constants for the per-port phy management register block
package phy_regs_pkg;

  // ----------------------------------------------------------------------
  // register word indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [4:0] idx_special_mode   = 5'h1b; // crossover/fault ctl
  localparam logic [4:0] idx_cable_length   = 5'h1c; // cable length
  localparam logic [4:0] idx_int_flags      = 5'h1d; // interrupt flags
  localparam logic [4:0] idx_int_mask       = 5'h1e; // interrupt mask
  localparam logic [4:0] idx_soft_device_reset_control_reg = 5'h1a; // soft reset control

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int pos_override     = 15; // crossover override bit
  localparam int pos_auto_enable  = 14; // crossover auto enable bit
  localparam int pos_manual_state = 13; // crossover manual state bit
  localparam int pos_sqe_off      = 11; // heartbeat disable bit
  localparam int pos_fault_enable = 5;  // far end fault enable bit
  localparam int pos_polarity     = 4;  // reversed polarity status bit
  localparam int pos_cable_hi     = 15; // cable estimate top bit
  localparam int pos_cable_lo     = 12; // cable estimate low bit
  localparam int pos_dev_reset    = 0;  // device phy reset strobe bit
  localparam int pos_soft_reset   = 1;  // phy soft reset hold bit

  // ----------------------------------------------------------------------
  // reset values and masks
  // ----------------------------------------------------------------------
  localparam logic [3:0]  cable_reset_val  = 4'h0;
  localparam logic [11:0] cable_low_val    = 12'h800;
  localparam logic [15:0] flag_mask_bits   = 16'h03fe; // bits 9..1
  localparam logic [15:0] flags_reset_val  = 16'h0000;
  localparam logic [15:0] mask_reset_val   = 16'h0000;

  // ----------------------------------------------------------------------
  // crossover modes
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    xover_none   = 3'b001,
    xover_cross  = 3'b010,
    xover_auto   = 3'b100
  } xover_mode_t;

endpackage

/* File: tb.sv */
// self-checking bench for the phy management register block
`timescale 1ns/10ps
module tb;
  import phy_regs_pkg::*;
  // ----------------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------------
  logic        mclk, rst;              // clock and async reset
  logic [6:0]  avs_address;            // bus byte address
  logic        avs_read, avs_write;    // bus strobes
  logic [31:0] avs_writedata;          // bus write data
  logic [31:0] avs_readdata;           // bus read data
  logic        avs_waitrequest;        // bus stall
  logic [1:0]  avs_response;           // bus response code
  logic        polarity_reversed, fiber_mode, auto_mdix_strap;
  logic        manual_mdix_strap, link_100_copper, cable_fault;
  logic [3:0]  cable_length_in;        // raw estimate
  logic        link_status, energy_detected;
  logic [9:1]  ev;                     // pulse event sources
  logic        crossover_auto, crossover_swap, far_end_fault_enable;
  logic        sqe_test_off, phy_irq;
  int          err_total, n_tests;     // mismatch and compare counts
  int          mask_m, flags_m;        // model of mask and flag state
  logic [31:0] seed;                   // xorshift state
  logic [15:0] rdv;                    // last read value
  logic [1:0]  rsp;                    // last response code
  logic [3:0]  cl;                     // cable value under test
  logic [2:0]  c;                      // crossover code under test

  phy_mdix_cable_irq_flags dut_u (
    .mclk(mclk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h3),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .polarity_reversed(polarity_reversed),
    .fiber_mode(fiber_mode), .auto_mdix_strap(auto_mdix_strap),
    .manual_mdix_strap(manual_mdix_strap), .cable_length_in(cable_length_in),
    .link_100_copper(link_100_copper), .cable_fault(cable_fault),
    .link_status(link_status), .wake_event(ev[8]),
    .energy_detected(energy_detected), .negotiation_done(ev[6]),
    .remote_fault(ev[5]), .partner_ack(ev[3]),
    .parallel_detect_fault(ev[2]), .page_received(ev[1]),
    .crossover_auto(crossover_auto), .crossover_swap(crossover_swap),
    .far_end_fault_enable(far_end_fault_enable),
    .sqe_test_off(sqe_test_off), .phy_irq(phy_irq)
  );

  // ----------------------------------------------------------------------
  // clock, random source, compare and bus tasks
  // ----------------------------------------------------------------------
  always #10 mclk = ~mclk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // compare a register value
  task automatic chk_reg(input string nm, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // compare a single output pin
  task automatic chk_pin(input string nm, input logic e, g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask

  // one bus access, held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [4:0] idx,
                     input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address   <= {idx, 2'b00};
    avs_writedata <= {16'h0000, wd};
    avs_write     <= w;
    avs_read      <= !w;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      err_total++;
      $display("wrong value waitrequest expected 0 seen 1");
    end
    // answer edge: take data, then release the request
    rdv = avs_readdata[15:0];
    rsp = avs_response;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (!w && idx == idx_int_flags) flags_m = 0;
  endtask

  task automatic wr(input logic [4:0] idx, input logic [15:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rd(input logic [4:0] idx, input string nm,
                    input logic [15:0] e);
    bus(1'b0, idx, 16'h0000);
    chk_reg(nm, e, rdv);
    chk_reg("response", 16'h0000, {14'h0, rsp});
  endtask

  task automatic settle();
    repeat (3) @(posedge mclk);
  endtask

  // one event on source b; the model latches it only when enabled
  task automatic fire(input int b);
    @(posedge mclk);
    case (b)
      9: link_status <= 1'b1;
      7: energy_detected <= 1'b1;
      4: link_status <= 1'b0;
      default: ev[b] <= 1'b1;
    endcase
    @(posedge mclk);
    ev <= '0;
    if (mask_m[b]) flags_m = flags_m | (1 << b);
  endtask

  task automatic complete_run();
    $display("compares %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // watchdog against a hung handshake
  // ----------------------------------------------------------------------
  initial begin
    #400000;
    err_total++;
    complete_run();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    mclk = 0; rst = 1; avs_address = '0; avs_read = 0; avs_write = 0;
    avs_writedata = '0; seed = 32'd40487; ev = '0;
    err_total = 0; n_tests = 0; mask_m = 0; flags_m = 0;
    polarity_reversed = 0; auto_mdix_strap = 0; manual_mdix_strap = 0;
    cable_length_in = 4'h5; link_100_copper = 0; cable_fault = 0;
    link_status = 0; energy_detected = 0; fiber_mode = 1'(rnd());
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    settle();
    chk_pin("fault enable", fiber_mode, far_end_fault_enable);
    rd(idx_cable_length, "cable", {cable_reset_val, cable_low_val});
    rd(idx_int_flags, "flags", 16'h0000);
    rd(idx_int_mask, "mask", 16'h0000);
    wr(5'h05, 16'hffff);
    rd(5'h05, "unmapped", 16'h0000);
    $display("test reset values done");
    // polarity status follows the input and ignores writes
    repeat (4) begin
      polarity_reversed <= 1'(rnd());
      wr(idx_special_mode, 16'h0010);
      bus(1'b0, idx_special_mode, 16'h0000);
      chk_reg("polarity", {11'h0, polarity_reversed, 4'h0},
              rdv & 16'h0010);
    end
    $display("test polarity done");
    // straps for codes 0..3, register codes 00, 01, 10 (never 11)
    for (int k = 0; k < 7; k++) begin
      c = (k < 4) ? k[2:0] : 3'(k - 4);
      {auto_mdix_strap, manual_mdix_strap} <= (k < 4) ? k[1:0] : 2'b10;
      wr(idx_special_mode, (k < 4) ? 16'h0000 : {1'b1, c[1:0], 13'h0});
      settle();
      chk_pin("xover auto", c[1], crossover_auto);
      chk_pin("xover swap", !c[1] && c[0], crossover_swap);
    end
    $display("test crossover done");
    // device reset without hold restores sticky defaults
    wr(idx_special_mode, 16'ha820);
    settle();
    chk_pin("sqe off", 1'b1, sqe_test_off);
    wr(idx_soft_device_reset_control_reg, 16'h0001);
    bus(1'b0, idx_special_mode, 16'h0000);
    chk_reg("sticky", {10'h0, fiber_mode, polarity_reversed, 4'h0},
            rdv & 16'he830);
    // with the hold bit set the sticky bits survive
    wr(idx_soft_device_reset_control_reg, 16'h0002);
    wr(idx_special_mode, 16'ha800);
    wr(idx_soft_device_reset_control_reg, 16'h0003);
    bus(1'b0, idx_special_mode, 16'h0000);
    chk_reg("kept", {10'h2a0, fiber_mode, polarity_reversed, 4'h0},
            rdv & 16'he830);
    settle();
    chk_pin("sqe kept", 1'b1, sqe_test_off);
    wr(idx_soft_device_reset_control_reg, 16'h0000);
    $display("test sticky done");
    // estimate loads only on a clean copper link
    cl = 4'(rnd());
    cable_length_in <= cl;
    link_100_copper <= 1'b1;
    wr(idx_cable_length, {4'h0, cable_low_val});
    settle();
    rd(idx_cable_length, "cable", {cl, cable_low_val});
    cable_length_in <= ~cl;
    cable_fault <= 1'b1;
    settle();
    rd(idx_cable_length, "cable held", {cl, cable_low_val});
    $display("test cable done");
    // each enabled source latches, raises irq and clears on read
    mask_m = 16'h03fe;
    wr(idx_int_mask, 16'hffff);
    rd(idx_int_mask, "mask", 16'(mask_m));
    wr(idx_int_flags, 16'h03fe);
    rd(idx_int_flags, "flags ro", 16'h0000);
    for (int b = 9; b >= 1; b--) begin
      fire(b);
      settle();
      chk_pin("irq set", 1'b1, phy_irq);
      rd(idx_int_flags, "flag", 16'(flags_m));
      rd(idx_int_flags, "cleared", 16'h0000);
      settle();
      chk_pin("irq clear", 1'b0, phy_irq);
    end
    // masked sources never latch
    mask_m = 16'h03fe & ~16'h0044;
    wr(idx_int_mask, 16'(mask_m));
    fire(2);
    fire(6);
    settle();
    chk_pin("irq masked", 1'b0, phy_irq);
    rd(idx_int_flags, "masked", 16'(flags_m));
    $display("test interrupts done");
    complete_run();
  end
endmodule
